// >>> dv/resampler_properties.sv
// Port-level assertions of the fractional resampler, bound to its top module.
module resampler_properties #(
	parameter int LATENCY = 500
) (
	input wire logic                              clk,
	input wire logic                              rst,
	input wire logic                              in_vld,
	input wire resampler_pkg::in_port_s           in_word,
	input wire logic                              in_rdy,
	input wire logic                              out_rdy,
	input wire logic                              out_vld,
	input wire logic [resampler_pkg::SAMPLE_W-1:0] out_dat,
	input wire logic [1:0]                        out_flags
);
	default clocking cb @(posedge clk); endclocking

	logic [7:0] sr_age_r;

	// Cycles since the last soft-reset write, saturating.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sr_age_r <= 8'hff;
		end else if (in_vld && in_word.soft_reset) begin
			sr_age_r <= 8'h00;
		end else if (sr_age_r != 8'hff) begin
			sr_age_r <= sr_age_r + 8'h01;
		end
	end

	AST_RESET_OUT: assert property (rst |-> !out_vld && out_dat == '0 && out_flags == 2'b00)
		else $error("outputs not cleared in reset");
	AST_RESET_RDY: assert property (rst |-> in_rdy)
		else $error("input ready low in reset");
	AST_RELEASE: assert property ($fell(rst) |-> !out_vld && out_flags == 2'b00)
		else $error("outputs not clear after reset release");
	AST_START_AT: assert property (disable iff (rst) $rose(out_vld) |-> $past(out_rdy, LATENCY))
		else $error("output started off the ready reference");
	AST_NO_EARLY: assert property (disable iff (rst) $rose(out_rdy) && !out_vld |=> !out_vld [*8])
		else $error("output started early");
	AST_VLD_STAYS: assert property (disable iff (rst) $fell(out_vld) |-> sr_age_r < 8'h20)
		else $error("output valid dropped without soft reset");
	AST_SR_CLEARS: assert property (disable iff (rst) in_vld && in_word.soft_reset && in_rdy
		|-> ##[1:16] !out_vld)
		else $error("soft reset did not stop output");
	AST_DAT_HOLD: assert property (disable iff (rst) out_vld && out_flags[0] |-> $stable(out_dat))
		else $error("data changed on empty read");

	COV_START: cover property (disable iff (rst) $rose(out_vld));
	COV_SOFT: cover property (disable iff (rst) out_vld && in_vld && in_word.soft_reset);
	COV_EMPTY: cover property (disable iff (rst) out_vld && out_flags[0]);
endmodule

bind fractional_resampler resampler_properties #(.LATENCY(LATENCY)) u_props (.clk(clk), .rst(rst),
	.in_vld(in_vld), .in_word(in_word), .in_rdy(in_rdy), .out_rdy(out_rdy), .out_vld(out_vld),
	.out_dat(out_dat), .out_flags(out_flags));

// >>> dv/stream_partner.sv
// Upstream sample writer and downstream ready source for the resampler.
module stream_partner (
	input  wire logic               clk,
	input  wire logic               in_rdy,
	output logic                    in_vld,
	output resampler_pkg::in_port_s in_word,
	output logic                    out_rdy
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		in_vld = 1'b0;
		in_word = '0;
		out_rdy = 1'b0;
	end

	// Writes n words back to back, pausing while back-pressure is shown.
	task automatic put(input logic sr, input logic [29:0] st, input logic [31:0] d, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			if (!in_rdy) in_vld = 1'b0;
			while (!in_rdy) @(negedge clk);
			in_vld = 1'b1;
			in_word = '{sr, st, d};
		end
		@(negedge clk);
		in_vld = 1'b0;
		// An idle port shows no stale word.
		in_word = ~in_word;
	endtask

	task automatic ready(input logic v);
		@(negedge clk);
		out_rdy = v;
	endtask
endmodule

// >>> dv/tb.sv
// Self-checking bench of the fractional resampler.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int LAT = 40;
	localparam int NS  = 8;

	logic                    clk = 1'b0;
	logic                    rst = 1'b0;
	logic                    in_vld;
	resampler_pkg::in_port_s in_word;
	logic                    in_rdy;
	logic                    out_rdy;
	logic                    out_vld;
	logic [31:0]             out_dat;
	logic [1:0]              out_flags;
	int                      failures = 0;
	int                      n_checks = 0;
	int                      cyc = 0;
	int                      n_bp = 0;

	always #25 clk = ~clk;

	// Counts cycles in which the input port shows back-pressure.
	always @(negedge clk) begin
		if (in_rdy === 1'b0) begin
			n_bp++;
		end
	end

	fractional_resampler #(.LATENCY(LAT)) dut (.clk(clk), .rst(rst), .in_vld(in_vld), .in_word(in_word),
		.in_rdy(in_rdy), .out_rdy(out_rdy), .out_vld(out_vld), .out_dat(out_dat), .out_flags(out_flags));

	stream_partner u_src (.clk(clk), .in_rdy(in_rdy), .in_vld(in_vld), .in_word(in_word), .out_rdy(out_rdy));

	// Outputs expected from n inputs at a fixed step, phase starting at zero.
	function automatic int exp_count(input logic [29:0] st, input int n);
		logic [31:0] u;
		logic [31:0] t;
		int c;
		u = 32'h0;
		c = 0;
		for (int i = 0; i < n; i++) begin
			t = u + {2'b00, st};
			c++;
			if (t < resampler_pkg::PHASE_ONE) begin
				c++;
				t = t + {2'b00, st};
			end
			u = t - resampler_pkg::PHASE_ONE;
		end
		return c;
	endfunction

	task automatic report_and_stop();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic reset_state();
		`CHK(in_rdy, 1'b1)
		`CHK(out_vld, 1'b0)
		`CHK(out_flags, 2'b00)
		`CHK(out_dat, 32'h0)
	endtask

	// Soft reset, a burst, then ready: checks start time, count and data.
	task automatic run(input logic [29:0] st, input logic [31:0] d, input int ns, input logic [31:0] last,
		input logic zero);
		int n;
		int k;
		u_src.ready(1'b0);
		u_src.put(1'b1, st, 32'h0, 1);
		repeat (20) @(negedge clk);
		`CHK(out_vld, 1'b0)
		u_src.put(1'b0, st, d, ns);
		u_src.ready(1'b1);
		n = 0;
		while (out_vld !== 1'b1 && n < 2 * LAT) begin
			@(negedge clk);
			n++;
		end
		`CHK(n, LAT)
		k = 0;
		repeat (150) begin
			`CHK(out_vld, 1'b1)
			if (out_flags[0] === 1'b0) begin
				k++;
				if (zero) `CHK(out_dat, 32'h0)
			end
			@(negedge clk);
		end
		`CHK(k, exp_count(st, ns))
		`CHK(out_flags[0], 1'b1)
		`CHK(out_flags[1], 1'b1)
		`CHK(out_dat, last)
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			report_and_stop();
		end
	end

	// Reset rises after time zero so the asynchronous reset sees a real edge.
	initial begin
		#1;
		rst = 1'b1;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		reset_state();
		run(30'h2000_0000, 32'h0100_0100, 28, 32'h0100_0100, 1'b0);
		`CHK(n_bp != 0, 1'b1)
		run(30'h2ccc_cccd, 32'h7fff_8001, NS, 32'h432f_bcd0, 1'b0);
		run(30'h2000_0000, 32'h0000_0000, NS, 32'h0000_0000, 1'b1);
		report_and_stop();
	end
endmodule

// >>> hdl/fractional_resampler.sv
// Fractional resampler: phase control, coefficient kernels, FIR sum and timed output.

// Function
// - Output is the 16-tap sum of windowed inputs times per-tap coefficients.
// - Coefficient equals F[s] plus alpha times G[s], s from tap and phase.
// - Two tables indexed by s hold F and differences G of F.
// - Coefficient table provides 256 entries per tap interval.
// - Each input yields one or two valid outputs by timing offset.
// - Compute path makes two candidates per input; invalid ones are dropped.
// - Table index and fraction are computed anew for every input sample.
// - Any ratio between 1.4286 and 2.0 is accepted.
// - Phase step is adjustable per sample at fine resolution.
// - Samples are 16-bit I and Q; input path 32, pair path 64 bits.
// - Output FIFO removes idle cycles for an uninterrupted output stream.
// - Input to output latency is fixed at 500 output clock cycles.
// - Input port is a FIFO write port tolerating bursts.
// - Internal streams transfer only when ready and valid are both high.
// - Input side sustains one word per four cycles, the length of one kernel pass.
// - Full range of nominal input sample rates is supported.
// - Output valid stays high once started until a soft reset; underflow flags accompany data.
// - All 16 coefficients are made at once, then interleaved over four outputs.
// - Soft reset clears phase accumulator, output FIFO and filter overlap memory.
// - Programmable full when under 16 free entries; 15 further writes still accepted.
// - Output starts exactly 500 cycles after output ready is asserted.
// - Internal FIFO empty indications appear as two flag bits on the output.
module fractional_resampler #(
	parameter int IN_DEPTH  = resampler_pkg::IN_DEPTH,
	parameter int OUT_DEPTH = resampler_pkg::OUT_DEPTH,
	parameter int LATENCY   = resampler_pkg::OUT_LATENCY_CYC
) (
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	input  wire logic                                  in_vld,
	input  wire resampler_pkg::in_port_s               in_word,
	output logic                                       in_rdy,
	input  wire logic                                  out_rdy,
	output logic                                       out_vld,
	output logic [resampler_pkg::SAMPLE_W-1:0]         out_dat,
	output logic [1:0]                                 out_flags
);
	localparam int T  = resampler_pkg::TAPS;
	localparam int LW = resampler_pkg::LANE_W;
	localparam int CW = resampler_pkg::COEF_W;
	localparam int SW = resampler_pkg::SUM_W;

	// Table value and difference for index s; the shape is a unit-gain triangle.
	function automatic logic signed [CW-1:0] f_tab(input logic [12:0] s);
		logic [12:0] tri_v;
		tri_v = (s < 13'(resampler_pkg::TABLE_HALF)) ? s : 13'(resampler_pkg::TABLE_SIZE) - s;
		return CW'(tri_v * 13'(resampler_pkg::TABLE_GAIN));
	endfunction

	function automatic logic signed [CW-1:0] g_tab(input logic [11:0] s);
		return f_tab({1'b0, s} + 13'd1) - f_tab({1'b0, s});
	endfunction

	// Input FIFO.
	resampler_pkg::in_entry_s in_head;
	logic                     in_head_vld;
	logic                     in_pop;
	logic                     in_pf;

	sample_fifo #(
		.W       ($bits(resampler_pkg::in_entry_s)),
		.DEPTH   (IN_DEPTH),
		.PF_FREE (resampler_pkg::PF_FREE_MIN)
	) u_in_fifo (
		.clk       (clk),
		.rst       (rst),
		.clear     (1'b0),
		.wr_vld    (in_vld),
		.wr_rdy    (),
		.wr_dat    ({in_word.soft_reset, in_word.step, in_word.dat}),
		.rd_vld    (in_head_vld),
		.rd_rdy    (in_pop),
		.rd_dat    (in_head),
		.prog_full (in_pf)
	);

	// Ready drops early so up to the in-flight count still fits after it falls.
	assign in_rdy = !in_pf;

	// Control section: phase accumulator and overlap window.
	logic [31:0]                          mu_r;
	logic [T-1:0][resampler_pkg::SAMPLE_W-1:0] win_r;
	resampler_pkg::ctl_rec_s              ctl_r;
	logic                                 ctl_vld_r;
	logic                                 ctl_rdy;
	logic                                 flush;
	logic [31:0]                          m0;
	logic [31:0]                          m1;
	logic                                 v0;
	logic                                 v1;

	assign in_pop = in_head_vld && (!ctl_vld_r || ctl_rdy);
	assign flush  = in_pop && in_head.soft_reset;

	always_comb begin
		v0 = (mu_r < resampler_pkg::PHASE_ONE);
		m0 = v0 ? mu_r + 32'(in_head.step) : mu_r;
		v1 = v0 && (m0 < resampler_pkg::PHASE_ONE);
		m1 = v1 ? m0 + 32'(in_head.step) : m0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mu_r  <= resampler_pkg::PHASE_INIT;
			win_r <= '0;
		end else if (flush) begin
			mu_r  <= resampler_pkg::PHASE_INIT;
			win_r <= '0;
		end else if (in_pop) begin
			mu_r  <= m1 - resampler_pkg::PHASE_ONE;
			win_r <= {win_r[T-2:0], in_head.dat};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl_vld_r <= 1'b0;
			ctl_r     <= '0;
		end else begin
			if (in_pop && !in_head.soft_reset) begin
				ctl_vld_r   <= 1'b1;
				ctl_r.valid <= {v1, v0};
				ctl_r.u0    <= mu_r[resampler_pkg::STEP_W-1:0];
				ctl_r.u1    <= m0[resampler_pkg::STEP_W-1:0];
				ctl_r.win   <= {win_r[T-2:0], in_head.dat};
			end else if (ctl_rdy) begin
				ctl_vld_r <= 1'b0;
			end
		end
	end

	// Coefficient interpolation kernel: all taps of one output in parallel.
	resampler_pkg::kern_state_e     kst_r;
	resampler_pkg::ctl_rec_s        krec_r;
	logic [resampler_pkg::STEP_W-1:0] ku;
	logic [T-1:0][CW-1:0]           coef;
	logic [CW-1:0]                  il_r [resampler_pkg::IL_SLOTS][T];
	logic [1:0]                     slot_r;
	resampler_pkg::pair_s           pair_r;
	logic                           pair_vld_r;
	logic                           pair_rdy;
	logic [LW-1:0]                  y_i;
	logic [LW-1:0]                  y_q;
	logic [1:0]                     rd_slot;

	assign ctl_rdy = (kst_r == resampler_pkg::K_IDLE);
	assign ku      = (kst_r == resampler_pkg::K_C0) ? krec_r.u0 : krec_r.u1;

	genvar gk;
	generate
		for (gk = 0; gk < T; gk++) begin : g_tap
			localparam int ALPHA_W_C = resampler_pkg::ALPHA_W;
			logic [11:0]          s_idx;
			logic [ALPHA_W_C-1:0] alpha;
			logic signed [33:0]   prod;
			always_comb begin
				s_idx = {4'(gk), ku[resampler_pkg::U_INDEX_MSB:resampler_pkg::U_INDEX_LSB]};
				alpha = ku[resampler_pkg::U_ALPHA_MSB:resampler_pkg::U_ALPHA_LSB];
				prod  = $signed({1'b0, alpha}) * g_tab(s_idx);
				coef[gk] = f_tab({1'b0, s_idx}) + CW'(prod >>> resampler_pkg::ALPHA_W);
			end
		end
	endgenerate

	// FIR sum kernel over the interleaved coefficient bank.
	assign rd_slot = (kst_r == resampler_pkg::K_C1) ? slot_r : slot_r + 2'd1;

	always_comb begin
		logic signed [SW-1:0] acc_i;
		logic signed [SW-1:0] acc_q;
		acc_i = '0;
		acc_q = '0;
		for (int k = 0; k < T; k++) begin
			// Operands are widened first so the product keeps all of its bits.
			acc_i = acc_i + SW'($signed(krec_r.win[k][LW-1:0])) * SW'($signed(il_r[rd_slot][k]));
			acc_q = acc_q + SW'($signed(krec_r.win[k][2*LW-1:LW])) * SW'($signed(il_r[rd_slot][k]));
		end
		y_i = acc_i[resampler_pkg::OUT_LSB +: LW];
		y_q = acc_q[resampler_pkg::OUT_LSB +: LW];
	end

	always_ff @(posedge clk) begin
		if (kst_r == resampler_pkg::K_C0 || kst_r == resampler_pkg::K_C1) begin
			for (int k = 0; k < T; k++) begin
				il_r[(kst_r == resampler_pkg::K_C0) ? slot_r : slot_r + 2'd1][k] <= coef[k];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			kst_r      <= resampler_pkg::K_IDLE;
			krec_r     <= '0;
			slot_r     <= '0;
			pair_r     <= '0;
			pair_vld_r <= 1'b0;
		end else begin
			if (pair_vld_r && pair_rdy) begin
				pair_vld_r <= 1'b0;
			end
			unique case (kst_r)
				resampler_pkg::K_IDLE: begin
					if (ctl_vld_r) begin
						krec_r <= ctl_r;
						kst_r  <= resampler_pkg::K_C0;
					end
				end
				resampler_pkg::K_C0: begin
					kst_r <= resampler_pkg::K_C1;
				end
				resampler_pkg::K_C1: begin
					pair_r.dat[LW*2-1:0] <= {y_q, y_i};
					kst_r                <= resampler_pkg::K_SUM;
				end
				resampler_pkg::K_SUM: begin
					if (!pair_vld_r || pair_rdy) begin
						pair_r.dat[resampler_pkg::PAIR_W-1:LW*2] <= {y_q, y_i};
						pair_r.valid <= krec_r.valid;
						pair_vld_r   <= 1'b1;
						slot_r       <= slot_r + 2'd2;
						kst_r        <= resampler_pkg::K_IDLE;
					end
				end
			endcase
		end
	end

	// Output select stage: keeps only flagged candidates.
	logic                             sel_r;
	logic                             of_wr;
	logic                             of_wr_rdy;
	logic [resampler_pkg::SAMPLE_W-1:0] of_wdat;
	logic                             of_rd_vld;
	logic                             of_rd;
	logic [resampler_pkg::SAMPLE_W-1:0] of_rdat;
	logic                             cand_ok;
	logic                             last_cand;

	assign cand_ok   = pair_r.valid[sel_r];
	assign last_cand = sel_r || !pair_r.valid[1];
	assign of_wr     = pair_vld_r && cand_ok;
	assign of_wdat   = sel_r ? pair_r.dat[resampler_pkg::PAIR_W-1:LW*2] : pair_r.dat[LW*2-1:0];
	assign pair_rdy  = pair_vld_r && (!cand_ok || of_wr_rdy) && last_cand;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_r <= 1'b0;
		end else if (pair_vld_r && (!cand_ok || of_wr_rdy)) begin
			sel_r <= last_cand ? 1'b0 : 1'b1;
		end
	end

	// Deep enough for everything prefilled during the start delay.
	sample_fifo #(
		.W       (resampler_pkg::SAMPLE_W),
		.DEPTH   (OUT_DEPTH),
		.PF_FREE (resampler_pkg::PF_FREE_MIN)
	) u_out_fifo (
		.clk       (clk),
		.rst       (rst),
		.clear     (flush),
		.wr_vld    (of_wr),
		.wr_rdy    (of_wr_rdy),
		.wr_dat    (of_wdat),
		.rd_vld    (of_rd_vld),
		.rd_rdy    (of_rd),
		.rd_dat    (of_rdat),
		.prog_full ()
	);

	// Start timer referenced to the downstream ready.
	logic [$clog2(LATENCY+1)-1:0] lat_r;
	logic                          started_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lat_r     <= '0;
			started_r <= 1'b0;
		end else if (flush) begin
			lat_r     <= '0;
			started_r <= 1'b0;
		end else if (!started_r && (out_rdy || lat_r != '0)) begin
			if (lat_r == ($clog2(LATENCY+1))'(LATENCY - 1)) begin
				started_r <= 1'b1;
			end
			lat_r <= lat_r + 1'b1;
		end
	end

	logic start_now;
	assign start_now = started_r || (!flush && lat_r == ($clog2(LATENCY+1))'(LATENCY - 1));
	assign of_rd     = start_now && of_rd_vld;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_vld   <= 1'b0;
			out_dat   <= '0;
			out_flags <= '0;
		end else if (flush) begin
			out_vld   <= 1'b0;
			out_flags <= '0;
		end else if (start_now) begin
			out_vld   <= 1'b1;
			out_dat   <= of_rd_vld ? of_rdat : out_dat;
			out_flags <= {!in_head_vld, !of_rd_vld};
		end
	end

endmodule

// >>> hdl/resampler_pkg.sv
// Shared constants and carrier types of the fractional resampler.
package resampler_pkg;

	localparam int TAPS          = 16;
	localparam int COEF_W        = 16;
	localparam int PHASES        = 256;
	localparam int PHASE_BITS    = 8;
	localparam int ALPHA_W       = 16;
	localparam int STEP_W        = 30;
	localparam int SAMPLE_W      = 32;
	localparam int LANE_W        = 16;
	localparam int PAIR_W        = 64;
	localparam int CANDS         = 2;
	localparam int IL_SLOTS      = 4;
	localparam int TABLE_SIZE    = TAPS * PHASES;
	localparam int TABLE_HALF    = TABLE_SIZE / 2;
	localparam int TABLE_GAIN    = 2;

	// Phase accumulator in units of one input interval, 30 fractional bits.
	localparam logic [31:0] PHASE_ONE  = 32'h4000_0000;
	localparam logic [31:0] PHASE_INIT = 32'h0000_0000;

	// Field positions of the phase fraction u.
	localparam int U_INDEX_MSB = 29;
	localparam int U_INDEX_LSB = 22;
	localparam int U_ALPHA_MSB = 21;
	localparam int U_ALPHA_LSB = 6;

	// Input FIFO and back-pressure.
	localparam int IN_DEPTH     = 32;
	localparam int PF_FREE_MIN  = 16;
	localparam int PF_INFLIGHT  = 15;

	// Output FIFO and fixed latency.
	localparam int OUT_DEPTH      = 512;
	localparam int OUT_LATENCY_NS = 1000;
	localparam int OUT_CLK_MHZ    = 500;
	localparam int OUT_LATENCY_CYC = OUT_LATENCY_NS * OUT_CLK_MHZ / 1000;

	// Product sum slice back to a 16-bit lane, coefficients are Q15.
	localparam int SUM_W   = 36;
	localparam int OUT_LSB = 15;

	typedef struct packed {
		logic                soft_reset;
		logic [STEP_W-1:0]   step;
		logic [SAMPLE_W-1:0] dat;
	} in_entry_s;

	typedef struct packed {
		logic [CANDS-1:0]                valid;
		logic [STEP_W-1:0]               u0;
		logic [STEP_W-1:0]               u1;
		logic [TAPS-1:0][SAMPLE_W-1:0]   win;
	} ctl_rec_s;

	typedef struct packed {
		logic [CANDS-1:0]  valid;
		logic [PAIR_W-1:0] dat;
	} pair_s;

	typedef struct packed {
		logic                soft_reset;
		logic [STEP_W-1:0]   step;
		logic [SAMPLE_W-1:0] dat;
	} in_port_s;

	typedef enum logic [1:0] {
		K_IDLE = 2'b00,
		K_C0   = 2'b01,
		K_C1   = 2'b11,
		K_SUM  = 2'b10
	} kern_state_e;

endpackage

// >>> hdl/sample_fifo.sv
// Synchronous flip-flop FIFO with programmable-full and flush.
module sample_fifo #(
	parameter int W       = 32,
	parameter int DEPTH   = 32,
	parameter int PF_FREE = 16
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clear,
	input  wire logic         wr_vld,
	output logic              wr_rdy,
	input  wire logic [W-1:0] wr_dat,
	output logic              rd_vld,
	input  wire logic         rd_rdy,
	output logic [W-1:0]      rd_dat,
	output logic              prog_full
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          do_wr;
	logic          do_rd;

	assign wr_rdy    = (cnt_r != (AW+1)'(DEPTH));
	assign rd_vld    = (cnt_r != '0);
	assign rd_dat    = mem_r[rp_r];
	assign prog_full = (cnt_r > (AW+1)'(DEPTH - PF_FREE));
	assign do_wr     = wr_vld && wr_rdy;
	assign do_rd     = rd_vld && rd_rdy;

	always_ff @(posedge clk) begin
		if (do_wr && !clear) begin
			mem_r[wp_r] <= wr_dat;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (clear) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (do_wr) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			end
			if (do_rd) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

endmodule
